// [rsc_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module rsc_asserts
  import rsc_pkg::*;
#(
  parameter int QUALIFY_CYCLES = 4,
  parameter int CORRUPT_CYCLES = 4,
  parameter int PULSE_CYCLES   = 3
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // Watched ports
  input wire rsc_req_t   bus_req,
  input wire logic [7:0] bus_rdata,
  input wire logic       supply_low,
  input wire logic       low_power_mode,
  input wire logic [7:0] threshold_code,
  input wire logic       watchdog_timeout,
  input wire logic       watchdog_run,
  input wire logic       device_reset,
  input wire rsc_core_t  core_ctrl,
  input wire logic       watchdog_timeout_flag,
  input wire logic       powerdown_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Run lengths of a qualifying low supply and of an undefined code
  logic [15:0] low_cnt;
  logic [15:0] bad_cnt;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_cnt <= 16'h0;
      bad_cnt <= 16'h0;
    end else begin
      low_cnt <= (supply_low && !low_power_mode && !device_reset) ? low_cnt + 16'h1 : 16'h0;
      bad_cnt <= (threshold_code inside {RSC_THR_2V10, RSC_THR_2V55, RSC_THR_3V15, RSC_THR_3V80}) ?
                 16'h0 : bad_cnt + 16'h1;
    end
  end
  sequence s_pcsp_once;
    !device_reset && core_ctrl == RSC_CORE_PCSP && watchdog_timeout_flag && powerdown_flag
    ##1 core_ctrl == RSC_CORE_NONE;
  endsequence
  property p_low_fire; (int'(low_cnt) == QUALIFY_CYCLES + 1) |-> device_reset; endproperty
  a_low_fire: assert property (p_low_fire) else $error("low supply did not reset");
  property p_thr_reload;
    (int'(bad_cnt) == CORRUPT_CYCLES) |-> ##[0:3] (device_reset && threshold_code == RSC_THR_RESET);
  endproperty
  a_thr_reload: assert property (p_thr_reload) else $error("bad code not reloaded");
  property p_wdt_run;
    watchdog_timeout && !low_power_mode && !device_reset |=> device_reset && watchdog_timeout_flag;
  endproperty
  a_wdt_run: assert property (p_wdt_run) else $error("run watchdog reset wrong");
  property p_wdt_lp; watchdog_timeout && low_power_mode && !device_reset |=> s_pcsp_once; endproperty
  a_wdt_lp: assert property (p_wdt_lp) else $error("low power watchdog wrong");
  property p_full_core; device_reset |-> core_ctrl == RSC_CORE_ALL && !watchdog_run; endproperty
  a_full_core: assert property (p_full_core) else $error("core not held");
  property p_wdt_start; $fell(device_reset) |-> watchdog_run && core_ctrl == RSC_CORE_NONE; endproperty
  a_wdt_start: assert property (p_wdt_start) else $error("watchdog not started");
  property p_prog_key;
    bus_req.wr && bus_req.addr == RSC_OFS_PROGCTRL && bus_req.wdata == RSC_PROG_RESET_KEY |=> device_reset;
  endproperty
  a_prog_key: assert property (p_prog_key) else $error("key write did not reset");
  property p_cause_hi;
    $past(bus_req.rd) && $past(bus_req.addr) == RSC_OFS_CAUSE |-> bus_rdata[7:4] == 4'h0;
  endproperty
  a_cause_hi: assert property (p_cause_hi) else $error("cause upper bits set");
endmodule : rsc_asserts
`default_nettype wire

// [rsc_pkg.sv]
`default_nettype none
package rsc_pkg;

  // Register map, byte offsets on the local register port
  localparam logic [1:0] RSC_OFS_THRESHOLD = 2'h0;
  localparam logic [1:0] RSC_OFS_CAUSE     = 2'h1;
  localparam logic [1:0] RSC_OFS_STATUS    = 2'h2;
  localparam logic [1:0] RSC_OFS_PROGCTRL  = 2'h3;

  // Threshold codes
  localparam logic [7:0] RSC_THR_2V10     = 8'h55;
  localparam logic [7:0] RSC_THR_2V55     = 8'h33;
  localparam logic [7:0] RSC_THR_3V15     = 8'h99;
  localparam logic [7:0] RSC_THR_3V80     = 8'haa;
  localparam logic [7:0] RSC_THR_RESET    = 8'h55;

  // Level index handed to the comparator
  localparam logic [1:0] RSC_LVL_2V10 = 2'h0;
  localparam logic [1:0] RSC_LVL_2V55 = 2'h1;
  localparam logic [1:0] RSC_LVL_3V15 = 2'h2;
  localparam logic [1:0] RSC_LVL_3V80 = 2'h3;

  // Programming control key that resets the device
  localparam logic [7:0] RSC_PROG_RESET_KEY = 8'h55;
  localparam logic [7:0] RSC_PROG_RESET_VAL = 8'h00;

  // Cause register field positions
  localparam int RSC_CAUSE_W        = 4;
  localparam int RSC_BIT_WDOG_CORR  = 0;
  localparam int RSC_BIT_THR_CORR   = 1;
  localparam int RSC_BIT_LOW_SUPPLY = 2;
  localparam int RSC_BIT_CTRL_CORR  = 3;
  localparam logic [3:0] RSC_CAUSE_RESET = 4'h0;

  // Status register field positions
  localparam int RSC_BIT_POWERDOWN = 4;
  localparam int RSC_BIT_TIMEOUT   = 5;

  // Timing
  localparam int RSC_CLK_PERIOD_NS     = 40;
  localparam int RSC_QUALIFY_TIME_NS   = 120000;
  localparam int RSC_CORRUPT_DELAY_NS  = 100000;
  localparam int RSC_QUALIFY_CYCLES    = (RSC_QUALIFY_TIME_NS + RSC_CLK_PERIOD_NS - 1) / RSC_CLK_PERIOD_NS;
  localparam int RSC_CORRUPT_CYCLES    = (RSC_CORRUPT_DELAY_NS + RSC_CLK_PERIOD_NS - 1) / RSC_CLK_PERIOD_NS;
  localparam int RSC_RESET_PULSE       = 16;
  localparam int RSC_CNT_W             = 16;
  localparam int RSC_PULSE_W           = 8;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rsc_req_t;

  // Core resource controls, high while the resource is held in its reset condition
  typedef struct packed {
    logic pc_clear;
    logic sp_top;
    logic int_en_clear;
    logic wdt_tb_clear;
    logic timers_off;
    logic io_input;
  } rsc_core_t;

  localparam rsc_core_t RSC_CORE_ALL  = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
  localparam rsc_core_t RSC_CORE_NONE = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
  localparam rsc_core_t RSC_CORE_PCSP = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

  function automatic logic rsc_thr_valid(input logic [7:0] code);
    return (code == RSC_THR_2V10) || (code == RSC_THR_2V55) ||
           (code == RSC_THR_3V15) || (code == RSC_THR_3V80);
  endfunction : rsc_thr_valid

  function automatic logic [1:0] rsc_thr_level(input logic [7:0] code);
    logic [1:0] lvl;
    lvl = RSC_LVL_2V10;
    if (code == RSC_THR_2V55) begin
      lvl = RSC_LVL_2V55;
    end else if (code == RSC_THR_3V15) begin
      lvl = RSC_LVL_3V15;
    end else if (code == RSC_THR_3V80) begin
      lvl = RSC_LVL_3V80;
    end
    return lvl;
  endfunction : rsc_thr_level

endpackage : rsc_pkg
`default_nettype wire

// [rsc_reset_source_controller.sv]
// Function
// - Low supply reset always armed in run modes; resets device and sets its cause flag.
// - Supply-low must persist beyond qualification time; shorter dips are ignored.
// - Threshold code 55h/33h/99h/aah selects 2.1V/2.55V/3.15V/3.8V.
// - Undefined threshold code resets after corruption delay, sets flag, reloads power-on value.
// - Threshold register powers up at 55h, the lowest level.
// - Qualified low-supply reset with valid code keeps threshold register contents.
// - Low supply reset is disabled in SLEEP and IDLE.
// - Cause bit 2 set by low supply reset; only software clears it.
// - Cause bit 1 set by undefined threshold code; only software clears it.
// - Cause register bits 7 to 4 read as zero.
// - Writing 55h to programming control register resets the whole device.
// - Run-mode watchdog timeout gives full reset and sets timeout flag.
// - Low-power watchdog timeout clears only PC and SP and sets timeout flag.
// - Power-on clears timeout and powerdown; run watchdog sets timeout; low-power watchdog sets both.
// - After power-on PC is zero and all interrupt enables are cleared.
// - After power-on watchdog and time bases clear and watchdog starts counting.
// - After power-on all timer modules are off.
// - After power-on all I/O ports are inputs.
// - After power-on stack pointer points to stack top.
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none

module rsc_reset_source_controller
  import rsc_pkg::*;
#(
  parameter int QUALIFY_CYCLES = RSC_QUALIFY_CYCLES,
  parameter int CORRUPT_CYCLES = RSC_CORRUPT_CYCLES,
  parameter int PULSE_CYCLES   = RSC_RESET_PULSE
) (
  // Clock and power-on reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Register port
  input  wire rsc_req_t   bus_req,
  output logic [7:0]      bus_rdata,
  // Supply monitor and operating mode
  input  wire logic       supply_low,
  input  wire logic       low_power_mode,
  output logic [1:0]      threshold_level,
  output logic [7:0]      threshold_code,
  // Watchdog and external corruption events
  input  wire logic       watchdog_timeout,
  input  wire logic       ctrl_corrupt_event,
  input  wire logic       wdt_ctrl_corrupt_event,
  output logic            watchdog_run,
  // Reset outputs
  output logic            device_reset,
  output rsc_core_t       core_ctrl,
  output logic            watchdog_timeout_flag,
  output logic            powerdown_flag
);

  // Counts are held in fixed-width counters; refuse what they cannot hold
  if (QUALIFY_CYCLES < 1 || QUALIFY_CYCLES >= (1 << RSC_CNT_W)) begin : g_chk_qual
    $error("QUALIFY_CYCLES out of range");
  end
  if (CORRUPT_CYCLES < 1 || CORRUPT_CYCLES >= (1 << RSC_CNT_W)) begin : g_chk_corr
    $error("CORRUPT_CYCLES out of range");
  end
  if (PULSE_CYCLES < 1 || PULSE_CYCLES >= (1 << RSC_PULSE_W)) begin : g_chk_pulse
    $error("PULSE_CYCLES out of range");
  end

  localparam logic [RSC_CNT_W-1:0]   QUAL_C  = RSC_CNT_W'(QUALIFY_CYCLES);
  localparam logic [RSC_CNT_W-1:0]   CORR_C  = RSC_CNT_W'(CORRUPT_CYCLES);
  localparam logic [RSC_PULSE_W-1:0] PULSE_C = RSC_PULSE_W'(PULSE_CYCLES);

  typedef struct packed {
    logic [7:0]             thr;
    logic [1:0]             level;
    logic [RSC_CAUSE_W-1:0] cause;
    logic                   to_flag;
    logic                   pd_flag;
    logic [7:0]             prog;
    logic [RSC_CNT_W-1:0]   qual_cnt;
    logic [RSC_CNT_W-1:0]   corr_cnt;
    logic [RSC_PULSE_W-1:0] rst_cnt;
    logic                   full_rst;
    logic                   wdt_run;
    rsc_core_t              core;
    logic [7:0]             rdata;
  } rsc_state_t;

  rsc_state_t state;
  rsc_state_t next_state;

  logic low_fire;
  logic corr_fire;
  logic wdt_full;
  logic wdt_lp;
  logic prog_fire;
  logic full_req;

  always_comb begin
    next_state       = state;
    next_state.rdata = 8'h00;

    // Reset sources other than the programming key write are ignored while a full reset is already running
    low_fire  = supply_low && !low_power_mode && !state.full_rst &&
                (state.qual_cnt == QUAL_C);
    corr_fire = !rsc_thr_valid(state.thr) && !state.full_rst &&
                (state.corr_cnt == CORR_C);
    wdt_full  = watchdog_timeout && !low_power_mode && !state.full_rst;
    wdt_lp    = watchdog_timeout && low_power_mode && !state.full_rst;
    prog_fire = bus_req.wr && (bus_req.addr == RSC_OFS_PROGCTRL) &&
                (bus_req.wdata == RSC_PROG_RESET_KEY);
    full_req  = low_fire || corr_fire || wdt_full || prog_fire;

    // Qualification: low must last more than QUAL_C cycles before acting
    if (supply_low && !low_power_mode && !state.full_rst) begin
      if (state.qual_cnt != QUAL_C) begin
        next_state.qual_cnt = state.qual_cnt + 16'h0001;
      end
    end else begin
      next_state.qual_cnt = '0;
    end

    if (!rsc_thr_valid(state.thr) && !state.full_rst) begin
      if (state.corr_cnt != CORR_C) begin
        next_state.corr_cnt = state.corr_cnt + 16'h0001;
      end
    end else begin
      next_state.corr_cnt = '0;
    end

    // Register writes
    if (bus_req.wr) begin
      if (bus_req.addr == RSC_OFS_THRESHOLD) begin
        next_state.thr = bus_req.wdata;
      end else if (bus_req.addr == RSC_OFS_CAUSE) begin
        next_state.cause = bus_req.wdata[RSC_CAUSE_W-1:0];
      end else if (bus_req.addr == RSC_OFS_STATUS) begin
        next_state.to_flag = bus_req.wdata[RSC_BIT_TIMEOUT];
        next_state.pd_flag = bus_req.wdata[RSC_BIT_POWERDOWN];
      end else if (bus_req.addr == RSC_OFS_PROGCTRL) begin
        next_state.prog = bus_req.wdata;
      end
    end

    // Hardware sets come after the write so that a set wins over a clear
    if (low_fire) begin
      next_state.cause[RSC_BIT_LOW_SUPPLY] = 1'b1;
    end
    if (corr_fire) begin
      next_state.cause[RSC_BIT_THR_CORR] = 1'b1;
      next_state.thr                     = RSC_THR_RESET;
    end
    if (ctrl_corrupt_event) begin
      next_state.cause[RSC_BIT_CTRL_CORR] = 1'b1;
    end
    if (wdt_ctrl_corrupt_event) begin
      next_state.cause[RSC_BIT_WDOG_CORR] = 1'b1;
    end
    // Low supply reset leaves both flags unchanged
    if (wdt_full) begin
      next_state.to_flag = 1'b1;
    end
    if (wdt_lp) begin
      next_state.to_flag = 1'b1;
      next_state.pd_flag = 1'b1;
    end

    // Full reset pulse; threshold is left alone unless corrupt
    if (full_req) begin
      next_state.rst_cnt = PULSE_C;
      next_state.prog    = RSC_PROG_RESET_VAL;
    end else if (state.rst_cnt != '0) begin
      next_state.rst_cnt = state.rst_cnt - 8'h01;
    end
    next_state.full_rst = (next_state.rst_cnt != '0);
    // Watchdog restarts as soon as the reset pulse ends
    next_state.wdt_run  = !next_state.full_rst;

    if (next_state.full_rst) begin
      next_state.core = RSC_CORE_ALL;
    end else if (wdt_lp) begin
      next_state.core = RSC_CORE_PCSP;
    end else begin
      next_state.core = RSC_CORE_NONE;
    end

    next_state.level = rsc_thr_level(next_state.thr);

    // Read data stand one cycle after the strobe; cycles without a read strobe return zero
    if (bus_req.rd) begin
      if (bus_req.addr == RSC_OFS_THRESHOLD) begin
        next_state.rdata = state.thr;
      end else if (bus_req.addr == RSC_OFS_CAUSE) begin
        next_state.rdata = {4'h0, state.cause};
      end else if (bus_req.addr == RSC_OFS_STATUS) begin
        next_state.rdata = {2'b00, state.to_flag, state.pd_flag, 4'h0};
      end else if (bus_req.addr == RSC_OFS_PROGCTRL) begin
        next_state.rdata = state.prog;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state.thr      <= RSC_THR_RESET;
      state.level    <= RSC_LVL_2V10;
      state.cause    <= RSC_CAUSE_RESET;
      state.to_flag  <= 1'b0;
      state.pd_flag  <= 1'b0;
      state.prog     <= RSC_PROG_RESET_VAL;
      state.qual_cnt <= '0;
      state.corr_cnt <= '0;
      state.rst_cnt  <= PULSE_C;
      state.full_rst <= 1'b1;
      state.wdt_run  <= 1'b0;
      state.core     <= RSC_CORE_ALL;
      state.rdata    <= 8'h00;
    end else begin
      state <= next_state;
    end
  end

  assign bus_rdata             = state.rdata;
  assign threshold_level       = state.level;
  assign threshold_code        = state.thr;
  assign watchdog_run          = state.wdt_run;
  assign device_reset          = state.full_rst;
  assign core_ctrl             = state.core;
  assign watchdog_timeout_flag = state.to_flag;
  assign powerdown_flag        = state.pd_flag;

endmodule : rsc_reset_source_controller

`default_nettype wire

// [rsc_reset_source_controller_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module rsc_reset_source_controller_tb_top import rsc_pkg::*;;
  localparam int QC = 4;
  localparam int CC = 4;
  logic       clk, sys_rst, supply_low, low_power_mode, watchdog_timeout;
  logic       ctrl_corrupt_event, wdt_ctrl_corrupt_event, watchdog_run, device_reset;
  logic       watchdog_timeout_flag, powerdown_flag;
  rsc_req_t   bus_req;
  rsc_core_t  core_ctrl;
  logic [7:0] bus_rdata, threshold_code, rv;
  logic [1:0] threshold_level;
  logic [31:0] seed;
  int         bad_count, compares, exp_cause;
  logic [7:0] codes [4] = '{8'h55, 8'h33, 8'h99, 8'haa};
  rsc_reset_source_controller #(.QUALIFY_CYCLES(QC), .CORRUPT_CYCLES(CC), .PULSE_CYCLES(3)) dut (
    .clk(clk), .sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata(bus_rdata), .supply_low(supply_low),
    .low_power_mode(low_power_mode), .threshold_level(threshold_level), .threshold_code(threshold_code),
    .watchdog_timeout(watchdog_timeout), .ctrl_corrupt_event(ctrl_corrupt_event),
    .wdt_ctrl_corrupt_event(wdt_ctrl_corrupt_event), .watchdog_run(watchdog_run),
    .device_reset(device_reset), .core_ctrl(core_ctrl), .watchdog_timeout_flag(watchdog_timeout_flag),
    .powerdown_flag(powerdown_flag));
  always #20 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk) bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus_req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) bus_req.rd <= 1'b0;
    #1 chk(bus_rdata, e);
  endtask : rd
  // Bounded wait for the device reset to reach a level
  task automatic wait_lvl(input logic v, input int n);
    repeat (n) begin
      if (device_reset !== v) begin
        @(posedge clk);
        #1;
      end
    end
    chk({7'h0, device_reset}, {7'h0, v});
  endtask : wait_lvl
  task automatic wdt(input logic lp);
    @(posedge clk) watchdog_timeout <= 1'b1;
    low_power_mode <= lp;
    @(posedge clk) watchdog_timeout <= 1'b0;
    low_power_mode <= 1'b0;
  endtask : wdt
  task automatic give_verdict;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  initial begin
    #(40 * 20000);
    bad_count++;
    give_verdict;
  end
  initial begin
    clk = 0; sys_rst = 1; supply_low = 0; low_power_mode = 0; watchdog_timeout = 0; bus_req = '0;
    ctrl_corrupt_event = 0; wdt_ctrl_corrupt_event = 0; bad_count = 0; compares = 0; exp_cause = 0;
    seed = 32'h17d57c8d;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    wait_lvl(1'b0, 20);
    chk(threshold_code, 8'h55);
    chk({6'h0, watchdog_timeout_flag, powerdown_flag}, 8'h00);
    rd(RSC_OFS_THRESHOLD, 8'h55);
    $display("test power_on done");
    for (int i = 0; i < 4; i++) begin
      wr(RSC_OFS_THRESHOLD, codes[i]);
      repeat (2) @(posedge clk);
      #1 chk({6'h0, threshold_level}, i[7:0]);
    end
    wr(RSC_OFS_THRESHOLD, 8'h99);
    @(posedge clk) supply_low <= 1'b1;
    repeat (QC) @(posedge clk);
    supply_low <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk({7'h0, device_reset}, 8'h00);
    @(posedge clk) supply_low <= 1'b1;
    repeat (QC + 2) @(posedge clk);
    supply_low <= 1'b0;
    #1 chk({7'h0, device_reset}, 8'h01);
    wait_lvl(1'b0, 20);
    exp_cause = exp_cause | 4;
    rd(RSC_OFS_CAUSE, exp_cause[7:0]);
    rd(RSC_OFS_THRESHOLD, 8'h99);
    wr(RSC_OFS_CAUSE, 8'h00);
    exp_cause = 0;
    rd(RSC_OFS_CAUSE, 8'h00);
    @(posedge clk) low_power_mode <= 1'b1;
    supply_low <= 1'b1;
    repeat (QC + 3) @(posedge clk);
    #1 chk({7'h0, device_reset}, 8'h00);
    @(posedge clk) supply_low <= 1'b0;
    low_power_mode <= 1'b0;
    $display("test low_supply done");
    wdt(1'b0);
    #1 chk({6'h0, device_reset, watchdog_timeout_flag}, 8'h03);
    wait_lvl(1'b0, 20);
    rd(RSC_OFS_STATUS, 8'h20);
    wr(RSC_OFS_STATUS, 8'h00);
    wdt(1'b1);
    #1 chk({5'h0, device_reset, watchdog_timeout_flag, powerdown_flag}, 8'h03);
    chk({2'h0, core_ctrl}, 8'h30);
    rd(RSC_OFS_STATUS, 8'h30);
    rd(RSC_OFS_THRESHOLD, 8'h99);
    wr(RSC_OFS_STATUS, 8'h00);
    $display("test watchdog done");
    seed = lfsr(seed);
    rv = (seed[7:0] inside {8'h55, 8'h33, 8'h99, 8'haa}) ? 8'h12 : seed[7:0];
    wr(RSC_OFS_THRESHOLD, rv);
    wait_lvl(1'b1, CC + 10);
    wait_lvl(1'b0, 20);
    exp_cause = exp_cause | 2;
    rd(RSC_OFS_CAUSE, exp_cause[7:0]);
    rd(RSC_OFS_THRESHOLD, 8'h55);
    wr(RSC_OFS_PROGCTRL, 8'h5a);
    repeat (3) @(posedge clk);
    #1 chk({7'h0, device_reset}, 8'h00);
    rd(RSC_OFS_PROGCTRL, 8'h5a);
    wr(RSC_OFS_PROGCTRL, 8'h55);
    wait_lvl(1'b1, 3);
    wait_lvl(1'b0, 20);
    rd(RSC_OFS_PROGCTRL, 8'h00);
    $display("test corrupt_prog done");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(RSC_OFS_CAUSE, seed[7:0]);
      rd(RSC_OFS_CAUSE, {4'h0, seed[3:0]});
    end
    wr(RSC_OFS_CAUSE, 8'h00);
    @(posedge clk) ctrl_corrupt_event <= 1'b1;
    wdt_ctrl_corrupt_event <= 1'b1;
    @(posedge clk) ctrl_corrupt_event <= 1'b0;
    wdt_ctrl_corrupt_event <= 1'b0;
    wait_lvl(1'b0, 40);
    rd(RSC_OFS_CAUSE, 8'h09);
    $display("test cause_bits done");
    give_verdict;
  end
endmodule : rsc_reset_source_controller_tb_top
bind rsc_reset_source_controller rsc_asserts #(
  .QUALIFY_CYCLES(QUALIFY_CYCLES), .CORRUPT_CYCLES(CORRUPT_CYCLES), .PULSE_CYCLES(PULSE_CYCLES)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata(bus_rdata), .supply_low(supply_low),
  .low_power_mode(low_power_mode), .threshold_code(threshold_code), .watchdog_timeout(watchdog_timeout),
  .watchdog_run(watchdog_run), .device_reset(device_reset), .core_ctrl(core_ctrl),
  .watchdog_timeout_flag(watchdog_timeout_flag), .powerdown_flag(powerdown_flag));
`default_nettype wire
